// *** dv/host_mcu_model.sv ***
`timescale 1ns/10ps
module host_mcu_model (
    input  wire logic ref_clk,
    input  wire logic resetPinOe,
    output logic       resetPinLevel,
    output logic       pullReset,
    output logic       modeWrite,
    output logic [7:0] modeWriteAddr,
    output logic [2:0] modeWriteData
);
    // ------------------------------------------------------------
    // Host side of the mode register and the reset line
    // ------------------------------------------------------------
    // Pull-up on the shared reset line: low while either side pulls
    assign resetPinLevel = !(resetPinOe || pullReset);
    initial begin
        pullReset = 1'b0;
        modeWrite = 1'b0;
        modeWriteAddr = 8'h00;
        modeWriteData = 3'h0;
    end
    task automatic write(input logic [7:0] a, input logic [2:0] d);
        @(posedge ref_clk);
        modeWrite <= 1'b1;
        modeWriteAddr <= a;
        modeWriteData <= d;
        @(posedge ref_clk);
        modeWrite <= 1'b0;
        // Released lines carry garbage, not the last value
        modeWriteAddr <= ~a;
        modeWriteData <= ~d;
    endtask
    task automatic hold_reset(input int n);
        @(posedge ref_clk);
        pullReset <= 1'b1;
        repeat (n) @(posedge ref_clk);
        pullReset <= 1'b0;
    endtask
endmodule

// *** dv/sbc_mode_chk.sv ***
`timescale 1ns/10ps
module sbc_mode_chk
    import sbc_mode_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire config_s    cfg,
    input wire logic       modeWrite,
    input wire logic [7:0] modeWriteAddr,
    input wire logic [2:0] modeWriteData,
    input wire op_mode_e   mode_reg,
    input wire logic [4:0] resetSourceCode_reg,
    input wire logic       spiFailure_reg,
    input wire logic       hostResetPinOe_reg,
    input wire logic       rxdWakeLow_reg,
    input wire ctrl_s      ctrl_reg
);
    // ------------------------------------------------------------
    // Mode sequencing checks
    // ------------------------------------------------------------
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    logic [11:0] rstCnt_reg;
    logic        cmdTaken;
    logic        onOrStby;
    assign cmdTaken = modeWrite && modeWriteAddr == MODE_CTRL_ADDR;
    assign onOrStby = mode_reg == MODE_STANDBY || mode_reg == MODE_NORMAL;

    // Saturates so a long undervoltage hold cannot wrap the count
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            rstCnt_reg <= 12'h000;
        else if (mode_reg != MODE_RESET)
            rstCnt_reg <= 12'h000;
        else if (rstCnt_reg != 12'hfff)
            rstCnt_reg <= rstCnt_reg + 12'h001;
    end

    AST_ONE_HOT: assert property ($onehot(mode_reg))
        else $error("mode not one-hot");
    AST_TO_NORMAL: assert property (cmdTaken && mode_reg == MODE_STANDBY
        && modeWriteData == CMD_NORMAL |=> mode_reg == MODE_NORMAL)
        else $error("standby did not go to normal");
    AST_TO_STBY: assert property (cmdTaken && mode_reg == MODE_NORMAL
        && modeWriteData == CMD_STANDBY |=> mode_reg == MODE_STANDBY)
        else $error("normal did not go to standby");
    AST_SLP_DIS: assert property (cmdTaken && onOrStby
        && modeWriteData == CMD_SLEEP && cfg.sleepDisableBit
        |=> spiFailure_reg && $stable(mode_reg) ##1 !spiFailure_reg)
        else $error("sleep disable not honoured");
    AST_ILL_SLP: assert property (cmdTaken && onOrStby
        && modeWriteData == CMD_SLEEP && !cfg.sleepDisableBit
        && (rxdWakeLow_reg || !(cfg.busWakeEnable || cfg.localWakeEnable))
        |=> mode_reg == MODE_RESET && resetSourceCode_reg == RSS_ILLEGAL_SL)
        else $error("illegal sleep not sent to reset");
    AST_RST_PIN: assert property (mode_reg == MODE_RESET
        && $past(mode_reg) == MODE_RESET
        |-> hostResetPinOe_reg && !ctrl_reg.spiEnable && !ctrl_reg.watchdogRun)
        else $error("reset mode controls wrong");
    AST_RST_ENTRY: assert property (mode_reg == MODE_RESET
        && $past(mode_reg) != MODE_RESET |-> hostResetPinOe_reg)
        else $error("reset pin released on reset entry");
    AST_RST_HOLD: assert property ($past(mode_reg) == MODE_RESET
        && (mode_reg == MODE_STANDBY || mode_reg == MODE_FNORMAL)
        |-> rstCnt_reg >= RESET_PULSE_CYC)
        else $error("reset left too early");
    AST_SLP_CTRL: assert property (mode_reg == MODE_SLEEP |->
        !ctrl_reg.hostSupplyOutput && !ctrl_reg.spiEnable
        && !ctrl_reg.tempProtEnable && ctrl_reg.busBiasEnable)
        else $error("sleep controls wrong");
    AST_STBY_CTRL: assert property (mode_reg == MODE_STANDBY |->
        !ctrl_reg.canActive && ctrl_reg.spiEnable && ctrl_reg.hostSupplyOutput)
        else $error("standby controls wrong");
    AST_SLP_EXIT: assert property ($past(mode_reg) == MODE_SLEEP
        && mode_reg != MODE_SLEEP |-> mode_reg inside {MODE_RESET, MODE_OFF})
        else $error("bad exit from sleep");

    cover property (mode_reg == MODE_SLEEP);
    cover property (mode_reg == MODE_OVERTEMP);
    cover property (mode_reg == MODE_FNORMAL);
endmodule

bind sbc_operating_mode_controller sbc_mode_chk u_sbc_mode_chk (
    .ref_clk, .rst, .cfg, .modeWrite, .modeWriteAddr, .modeWriteData,
    .mode_reg, .resetSourceCode_reg, .spiFailure_reg, .hostResetPinOe_reg,
    .rxdWakeLow_reg, .ctrl_reg);

// *** dv/testbench.sv ***
`timescale 1ns/10ps
module testbench
    import sbc_mode_pkg::*;
;
    // ------------------------------------------------------------
    // Bench
    // ------------------------------------------------------------
    logic ref_clk, rst, busActiveAsync, watchdogEnable, modeWrite;
    logic pullReset, resetPinLevel, spiFailure_reg, rxdWakeLow_reg;
    logic hostResetPinOut_reg, hostResetPinOe_reg;
    logic [7:0] modeWriteAddr;
    logic [2:0] modeWriteData, modeSelectField_reg;
    logic [4:0] resetSourceCode_reg;
    monitors_s  mon, monIn;
    config_s    cfg;
    op_mode_e   mode_reg;
    ctrl_s      ctrl_reg;
    int         n_mismatch, checks_done;

    always #5 ref_clk = ~ref_clk;
    always_comb begin
        monIn = mon;
        monIn.extResetReq = pullReset;
    end

    sbc_operating_mode_controller u_sbc_operating_mode_controller (
        .ref_clk, .rst, .monAsync(monIn), .busActiveAsync, .cfg,
        .modeWrite, .modeWriteAddr, .modeWriteData, .watchdogEnable,
        .mode_reg, .modeSelectField_reg, .resetSourceCode_reg,
        .spiFailure_reg, .hostResetPinOut_reg, .hostResetPinOe_reg,
        .rxdWakeLow_reg, .ctrl_reg);
    host_mcu_model u_host_mcu_model (.ref_clk, .resetPinOe(hostResetPinOe_reg),
        .resetPinLevel, .pullReset, .modeWrite, .modeWriteAddr,
        .modeWriteData);

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] e, input logic [31:0] a);
        checks_done++;
        if (a !== e) begin
            n_mismatch++;
            $display("mismatch t=%0t exp=%h got=%h", $time, e, a);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wait_mode(input op_mode_e m, input int bound);
        int i;
        i = 0;
        while (mode_reg !== m) begin
            if (i == bound) begin
                chk(m, mode_reg);
                report_and_stop();
            end
            cyc(1);
            i++;
        end
    endtask
    task automatic wr(input logic [2:0] d);
        u_host_mcu_model.write(MODE_CTRL_ADDR, d);
        #1;
    endtask

    task automatic t_boot;
        chk(MODE_OFF, mode_reg);
        chk(1, ctrl_reg.canHighZ);
        chk(MODE_SEL_RST_VAL, modeSelectField_reg);
        @(posedge ref_clk) mon.batPowerOn <= 1'b1;
        cyc(150);
        chk(MODE_OFF, mode_reg);
        wait_mode(MODE_RESET, 100);
        cyc(2);
        chk(0, resetPinLevel);
        chk(0, hostResetPinOut_reg);
        wait_mode(MODE_STANDBY, 300);
        chk(1, resetPinLevel);
    endtask
    task automatic t_cmds;
        wr(CMD_NORMAL);
        chk(MODE_NORMAL, mode_reg);
        chk(CMD_NORMAL, modeSelectField_reg);
        wr(CMD_STANDBY);
        chk(MODE_STANDBY, mode_reg);
        chk(0, ctrl_reg.canActive);
        u_host_mcu_model.write(8'h02, CMD_NORMAL);
        #1;
        chk(MODE_STANDBY, mode_reg);
        chk(CMD_STANDBY, modeSelectField_reg);
        @(posedge ref_clk) cfg.sleepDisableBit <= 1'b1;
        wr(CMD_SLEEP);
        chk(1, spiFailure_reg);
        chk(MODE_STANDBY, mode_reg);
        @(posedge ref_clk) cfg.sleepDisableBit <= 1'b0;
        wr(CMD_SLEEP);
        chk(MODE_RESET, mode_reg);
        chk(RSS_ILLEGAL_SL, resetSourceCode_reg);
        wait_mode(MODE_STANDBY, 300);
    endtask
    task automatic t_wake;
        @(posedge ref_clk) cfg <= '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
        busActiveAsync <= 1'b1;
        watchdogEnable <= 1'b1;
        cyc(5);
        chk(1, ctrl_reg.selectiveWake);
        chk(1, ctrl_reg.busBias2v5);
        chk(1, ctrl_reg.watchdogRun);
        @(posedge ref_clk) cfg.partialNetConfigValid <= 1'b0;
        busActiveAsync <= 1'b0;
        cyc(120);
        chk(0, ctrl_reg.selectiveWake);
        chk(0, ctrl_reg.busBias2v5);
        wr(CMD_SLEEP);
        chk(MODE_SLEEP, mode_reg);
        wr(CMD_NORMAL);
        chk(MODE_SLEEP, mode_reg);
        @(posedge ref_clk) mon.busWakeDet <= 1'b1;
        wait_mode(MODE_RESET, 10);
        chk(1, rxdWakeLow_reg);
        @(posedge ref_clk) mon.busWakeDet <= 1'b0;
        wait_mode(MODE_STANDBY, 300);
        wr(CMD_SLEEP);
        chk(MODE_RESET, mode_reg);
        wait_mode(MODE_STANDBY, 300);
        wr(CMD_NORMAL);
        // Pending wake clears one edge into normal, the pin one edge later
        cyc(2);
        chk(0, rxdWakeLow_reg);
        wr(CMD_STANDBY);
    endtask
    task automatic t_uv;
        @(posedge ref_clk) mon.hostSupplyUv <= 1'b1;
        wait_mode(MODE_RESET, 10);
        cyc(300);
        chk(MODE_RESET, mode_reg);
        @(posedge ref_clk) mon.hostSupplyUv <= 1'b0;
        wait_mode(MODE_STANDBY, 300);
    endtask
    task automatic t_fnorm_temp;
        @(posedge ref_clk) cfg.forcedNormalBootBit <= 1'b1;
        u_host_mcu_model.hold_reset(5);
        wait_mode(MODE_RESET, 10);
        wait_mode(MODE_FNORMAL, 300);
        @(posedge ref_clk) cfg.forcedNormalBootBit <= 1'b0;
        u_host_mcu_model.hold_reset(5);
        wait_mode(MODE_RESET, 10);
        wait_mode(MODE_FNORMAL, 300);
        @(posedge ref_clk) mon.tempOverAct <= 1'b1;
        wait_mode(MODE_OVERTEMP, 10);
        @(posedge ref_clk) mon.tempOverAct <= 1'b0;
        mon.tempBelowRel <= 1'b1;
        wait_mode(MODE_RESET, 10);
        @(posedge ref_clk) mon.tempBelowRel <= 1'b0;
        wait_mode(MODE_STANDBY, 300);
    endtask
    task automatic t_prio;
        @(posedge ref_clk) mon.tempOverAct <= 1'b1;
        mon.batPowerOff <= 1'b1;
        mon.batPowerOn <= 1'b0;
        cyc(4);
        chk(MODE_OFF, mode_reg);
        chk(1, ctrl_reg.canHighZ);
    endtask

    initial begin
        ref_clk = 1'b0;
        rst = 1'b1;
        mon = '0;
        cfg = '0;
        busActiveAsync = 1'b0;
        watchdogEnable = 1'b0;
        n_mismatch = 0;
        checks_done = 0;
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        cyc(3);
        t_boot();
        t_cmds();
        t_wake();
        t_uv();
        t_fnorm_temp();
        t_prio();
        report_and_stop();
    end
endmodule

// *** rtl/sbc_mode_pkg.sv ***
package sbc_mode_pkg;

    // Mode-control command values
    localparam logic [2:0] CMD_SLEEP   = 3'h1;
    localparam logic [2:0] CMD_STANDBY = 3'h4;
    localparam logic [2:0] CMD_NORMAL  = 3'h7;
    localparam logic [7:0] MODE_CTRL_ADDR = 8'h01;

    // Reset source codes
    localparam logic [4:0] RSS_POWER_ON   = 5'h00;
    localparam logic [4:0] RSS_EXTERNAL   = 5'h01;
    localparam logic [4:0] RSS_UNDERVOLT  = 5'h02;
    localparam logic [4:0] RSS_OVERTEMP   = 5'h03;
    localparam logic [4:0] RSS_WAKE       = 5'h04;
    localparam logic [4:0] RSS_ILLEGAL_SL = 5'h14;
    localparam logic [4:0] RSS_RST_VAL    = 5'h00;
    localparam logic [2:0] MODE_SEL_RST_VAL = 3'h4;

    // Timing in ns and derived cycles at 100 MHz
    localparam int CLK_PERIOD_NS = 10;
    localparam int STARTUP_NS    = 2000;
    localparam int STARTUP_CYC   = (STARTUP_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
    localparam int RESET_PULSE_NS  = 1000;
    localparam int RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_PERIOD_NS - 1)
                                     / CLK_PERIOD_NS;
    localparam int SILENCE_NS  = 1000;
    localparam int SILENCE_CYC = (SILENCE_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
    localparam int CNT_W = 12;

    typedef enum logic [6:0] {
        MODE_OFF      = 7'h01,
        MODE_RESET    = 7'h02,
        MODE_STANDBY  = 7'h04,
        MODE_NORMAL   = 7'h08,
        MODE_SLEEP    = 7'h10,
        MODE_FNORMAL  = 7'h20,
        MODE_OVERTEMP = 7'h40
    } op_mode_e;

    // Analogue/pin monitors
    typedef struct packed {
        logic batPowerOn;
        logic batPowerOff;
        logic tempOverAct;
        logic tempBelowRel;
        logic hostSupplyUv;
        logic extResetReq;
        logic busWakeDet;
        logic localWakeDet;
        logic diagWakeDet;
    } monitors_s;

    // Configuration bits
    typedef struct packed {
        logic busWakeEnable;
        logic localWakeEnable;
        logic partialNetEnable;
        logic partialNetConfigValid;
        logic sleepDisableBit;
        logic forcedNormalBootBit;
    } config_s;

    // Block controls driven from the mode
    typedef struct packed {
        logic hostSupplyOutput;
        logic canActive;
        logic spiEnable;
        logic watchdogRun;
        logic tempProtEnable;
        logic busBiasEnable;
        logic busBias2v5;
        logic selectiveWake;
        logic canHighZ;
    } ctrl_s;

endpackage

// *** rtl/sbc_operating_mode_controller.sv ***
`timescale 1ns/10ps

module sbc_operating_mode_controller
    import sbc_mode_pkg::*;
(
    input  wire logic      ref_clk,
    input  wire logic      rst,
    input  wire monitors_s monAsync,
    input  wire logic      busActiveAsync,
    input  wire config_s   cfg,
    input  wire logic      modeWrite,
    input  wire logic [7:0] modeWriteAddr,
    input  wire logic [2:0] modeWriteData,
    input  wire logic      watchdogEnable,
    output op_mode_e       mode_reg,
    output logic [2:0]     modeSelectField_reg,
    output logic [4:0]     resetSourceCode_reg,
    output logic           spiFailure_reg,
    output logic           hostResetPinOut_reg,
    output logic           hostResetPinOe_reg,
    output logic           rxdWakeLow_reg,
    output ctrl_s          ctrl_reg
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    monitors_s monMeta;
    monitors_s mon;
    logic      busMeta;
    logic      busActive;
    logic      hostResetPinIn;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            monMeta <= '0;
            mon     <= '0;
            busMeta <= 1'b0;
            busActive <= 1'b0;
        end else begin
            monMeta <= monAsync;
            mon     <= monMeta;
            busMeta <= busActiveAsync;
            busActive <= busMeta;
        end
    end

    // Reset pin input reads released whenever no external reset request holds it
    assign hostResetPinIn = ~mon.extResetReq;

    // ------------------------------------------------------------
    // Wake capture
    // ------------------------------------------------------------
    logic wakePending_reg;
    logic regularWake;
    logic anyWake;
    logic wakeSourceOn;

    assign wakeSourceOn = cfg.busWakeEnable | cfg.localWakeEnable;
    assign regularWake  = (mon.busWakeDet & cfg.busWakeEnable)
                        | (mon.localWakeDet & cfg.localWakeEnable);
    assign anyWake      = regularWake | mon.diagWakeDet;

    // No detection in overtemp or off; a pending wake stays flagged in overtemp but clears in off
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wakePending_reg <= 1'b0;
        end else if (mode_reg == MODE_OFF) begin
            wakePending_reg <= 1'b0;
        end else if (anyWake && mode_reg != MODE_OVERTEMP) begin
            wakePending_reg <= 1'b1;
        end else if (mode_reg == MODE_NORMAL || mode_reg == MODE_FNORMAL) begin
            wakePending_reg <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rxdWakeLow_reg <= 1'b0;
        end else begin
            rxdWakeLow_reg <= wakePending_reg
                            | (anyWake && mode_reg != MODE_OVERTEMP
                               && mode_reg != MODE_OFF);
        end
    end

    // ------------------------------------------------------------
    // Mode-select command decode
    // ------------------------------------------------------------
    logic cmdValid;
    logic cmdSleep;
    logic sleepOk;

    assign cmdValid = modeWrite && modeWriteAddr == MODE_CTRL_ADDR
                    && ctrl_reg.spiEnable;
    assign cmdSleep = cmdValid && modeWriteData == CMD_SLEEP
                    && (mode_reg == MODE_NORMAL || mode_reg == MODE_STANDBY);
    assign sleepOk  = !wakePending_reg && !anyWake && wakeSourceOn;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            modeSelectField_reg <= MODE_SEL_RST_VAL;
        end else if (cmdValid) begin
            modeSelectField_reg <= modeWriteData;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            spiFailure_reg <= 1'b0;
        end else begin
            spiFailure_reg <= cmdSleep && cfg.sleepDisableBit;
        end
    end

    // ------------------------------------------------------------
    // Counters for start-up, reset pulse and bus silence
    // ------------------------------------------------------------
    logic [CNT_W-1:0] timer_reg;
    logic [CNT_W-1:0] silence_reg;
    logic             uvHold_reg;
    logic             fromForced_reg;
    op_mode_e         modeNext;
    logic [4:0]       rssNext;
    logic             timerDone;

    assign timerDone = (mode_reg == MODE_OFF)
                     ? timer_reg >= CNT_W'(STARTUP_CYC)
                     : timer_reg >= CNT_W'(RESET_PULSE_CYC);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            timer_reg <= '0;
        end else if (modeNext != mode_reg) begin
            timer_reg <= '0;
        end else if (!timerDone && (mode_reg == MODE_RESET
                     || (mode_reg == MODE_OFF && mon.batPowerOn))) begin
            timer_reg <= timer_reg + CNT_W'(1);
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            silence_reg <= '0;
        end else if (busActive) begin
            silence_reg <= '0;
        end else if (silence_reg < CNT_W'(SILENCE_CYC)) begin
            silence_reg <= silence_reg + CNT_W'(1);
        end
    end

    // ------------------------------------------------------------
    // Mode state machine
    // ------------------------------------------------------------
    always_comb begin
        modeNext = mode_reg;
        rssNext  = resetSourceCode_reg;
        if (mon.batPowerOff) begin
            modeNext = MODE_OFF;
        end else if (mon.tempOverAct && mode_reg != MODE_OFF
                     && mode_reg != MODE_SLEEP) begin
            modeNext = MODE_OVERTEMP;
            rssNext  = RSS_OVERTEMP;
        end else if ((mon.hostSupplyUv || mon.extResetReq)
                     && mode_reg != MODE_OFF && mode_reg != MODE_SLEEP
                     && mode_reg != MODE_OVERTEMP
                     && mode_reg != MODE_RESET) begin
            modeNext = MODE_RESET;
            rssNext  = mon.hostSupplyUv ? RSS_UNDERVOLT : RSS_EXTERNAL;
        end else begin
            unique case (mode_reg)
                MODE_OFF: begin
                    if (mon.batPowerOn && timerDone) begin
                        modeNext = MODE_RESET;
                        rssNext  = RSS_POWER_ON;
                    end
                end
                MODE_OVERTEMP: begin
                    if (mon.tempBelowRel) begin
                        modeNext = MODE_RESET;
                    end
                end
                MODE_SLEEP: begin
                    if (anyWake) begin
                        modeNext = MODE_RESET;
                        rssNext  = RSS_WAKE;
                    end
                end
                MODE_RESET: begin
                    if (timerDone && !uvHold_reg && hostResetPinIn) begin
                        if (cfg.forcedNormalBootBit || fromForced_reg)
                            modeNext = MODE_FNORMAL;
                        else
                            modeNext = MODE_STANDBY;
                    end
                end
                MODE_STANDBY: begin
                    if (cmdValid && modeWriteData == CMD_NORMAL)
                        modeNext = MODE_NORMAL;
                end
                MODE_NORMAL: begin
                    if (cmdValid && modeWriteData == CMD_STANDBY)
                        modeNext = MODE_STANDBY;
                end
                MODE_FNORMAL: begin
                    modeNext = MODE_FNORMAL;
                end
                default: begin
                    modeNext = MODE_OFF;
                end
            endcase
            if (cmdSleep && !cfg.sleepDisableBit) begin
                if (sleepOk) begin
                    modeNext = MODE_SLEEP;
                end else begin
                    modeNext = MODE_RESET;
                    rssNext  = RSS_ILLEGAL_SL;
                end
            end
        end
    end

    // Off on first battery connection
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mode_reg <= MODE_OFF;
        end else begin
            mode_reg <= modeNext;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            resetSourceCode_reg <= RSS_RST_VAL;
        end else begin
            resetSourceCode_reg <= rssNext;
        end
    end

    // Remember causes that change how reset is left
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            uvHold_reg     <= 1'b0;
            fromForced_reg <= 1'b0;
        end else begin
            if (modeNext == MODE_RESET && mode_reg != MODE_RESET) begin
                fromForced_reg <= (mode_reg == MODE_FNORMAL);
            end
            if (modeNext == MODE_RESET && mon.hostSupplyUv) begin
                uvHold_reg <= 1'b1;
            end else if (!mon.hostSupplyUv) begin
                uvHold_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Per-mode block controls and reset pin
    // ------------------------------------------------------------
    ctrl_s ctrlNext;

    always_comb begin
        ctrlNext = '0;
        ctrlNext.selectiveWake = cfg.partialNetEnable
                               & cfg.partialNetConfigValid;
        unique case (modeNext)
            MODE_OFF: begin
                ctrlNext.canHighZ = 1'b1;
            end
            MODE_NORMAL: begin
                ctrlNext.hostSupplyOutput = 1'b1;
                ctrlNext.canActive        = 1'b1;
                ctrlNext.spiEnable        = 1'b1;
                ctrlNext.watchdogRun      = watchdogEnable;
                ctrlNext.tempProtEnable   = 1'b1;
            end
            MODE_FNORMAL: begin
                ctrlNext.hostSupplyOutput = 1'b1;
                ctrlNext.canActive        = 1'b1;
                ctrlNext.spiEnable        = 1'b1;
                ctrlNext.tempProtEnable   = 1'b1;
            end
            MODE_STANDBY: begin
                ctrlNext.hostSupplyOutput = 1'b1;
                ctrlNext.spiEnable        = 1'b1;
                ctrlNext.watchdogRun      = watchdogEnable;
                ctrlNext.tempProtEnable   = 1'b1;
                ctrlNext.busBiasEnable    = cfg.busWakeEnable;
                ctrlNext.busBias2v5       = cfg.busWakeEnable
                    & (silence_reg < CNT_W'(SILENCE_CYC));
            end
            MODE_SLEEP: begin
                ctrlNext.busBiasEnable = 1'b1;
                ctrlNext.busBias2v5    =
                    silence_reg < CNT_W'(SILENCE_CYC);
                ctrlNext.watchdogRun   = watchdogEnable;
            end
            MODE_RESET: begin
                ctrlNext.hostSupplyOutput = 1'b1;
                ctrlNext.tempProtEnable   = 1'b1;
            end
            MODE_OVERTEMP: begin
                ctrlNext.canHighZ = 1'b1;
            end
            default: begin
                ctrlNext.canHighZ = 1'b1;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= '0;
        end else begin
            ctrl_reg <= ctrlNext;
        end
    end

    // Open-drain reset pin: driven low except in running modes and in reset once the pulse is done with no undervoltage hold
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hostResetPinOut_reg <= 1'b0;
            hostResetPinOe_reg  <= 1'b1;
        end else begin
            hostResetPinOut_reg <= 1'b0;
            hostResetPinOe_reg  <= !(modeNext == MODE_NORMAL
                                  || modeNext == MODE_STANDBY
                                  || modeNext == MODE_FNORMAL
                                  || (modeNext == MODE_RESET
                                      && mode_reg == MODE_RESET
                                      && timerDone && !uvHold_reg));
        end
    end

endmodule
